// ---- design/crf_fifo.sv ----
`timescale 1ns/1ps
module crf_fifo #(
	parameter int WIDTH = crf_pkg::CRF_FRAME_W,
	parameter int DEPTH = crf_pkg::CRF_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("crf_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic empty;
	logic full;
	logic push;
	logic pop;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	// head shown without delay; the top registers it before software sees it
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// ========================================
	// pointers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	// ========================================
	// storage
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end
endmodule

// ---- design/crf_filter.sv ----
`timescale 1ns/1ps
module crf_filter (
	input wire logic [31:0] id_image,
	input wire logic [31:0] code_bank,
	input wire logic [31:0] mask_bank,
	input wire logic [1:0] lanes,
	input wire logic [31:0] lane_sel,
	output logic hit
);
	// one filter: bits with mask set are don't care
	logic [31:0] diff;

	assign diff = (id_image ^ code_bank) & ~mask_bank & lane_sel;
	assign hit = (lanes != 2'b00) && (diff == 32'h0000_0000);
endmodule

// ---- design/crf_pkg.sv ----
package crf_pkg;

	// ========================================
	// filter modes
	typedef enum logic [1:0] {
		CRF_MODE_TWO32 = 2'b00,
		CRF_MODE_FOUR16 = 2'b01,
		CRF_MODE_EIGHT8 = 2'b10,
		CRF_MODE_CLOSED = 2'b11
	} crf_mode_t;

	// ========================================
	// identifier register image field layout (32-bit bank view)
	localparam int CRF_BANK_W = 32;
	localparam int CRF_NUM_REGS = 8;
	localparam int CRF_HIT_W = 3;
	localparam logic [CRF_HIT_W-1:0] CRF_HIT_RESET = 3'h0;
	localparam int CRF_EXT_SRR_BIT = 20;
	localparam int CRF_EXT_IDE_BIT = 19;
	localparam int CRF_EXT_RTR_BIT = 0;
	localparam int CRF_STD_RTR_BIT = 20;
	localparam int CRF_STD_IDE_BIT = 19;

	// ========================================
	// a received frame as it leaves the background buffer
	typedef struct packed {
		logic [CRF_BANK_W-1:0] id_image;
		logic [3:0] dlc;
		logic [63:0] data;
		logic [CRF_HIT_W-1:0] hit;
	} crf_frame_t;

	localparam int CRF_FRAME_W = $bits(crf_frame_t);
	localparam int CRF_FIFO_DEPTH = 8;

endpackage

// ---- design/crf_rx_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - own sent frame caught in background buffer; not stored, flagged, or acked
// - loopback mode: own frames treated like any received frame
// - lost arbitration: keep receiving the winning frame normally
// - rejected or erroneous frame in background buffer is overwritten, never stored
// - full fifo plus new accepted frame: drop it, pulse overrun if enabled
// - fifo full: transmit unaffected, incoming frames dropped
// - freed fifo slot resumes acceptance with no software action
// - code registers define accepted standard or extended identifier pattern
// - mask bit set excludes that identifier bit from comparison
// - filter hit shown by rx full flag set to one
// - three-bit hit index reports accepting filter section
// - several hits: lowest numbered section is reported
// - four filter modes differing in filter count and width
// - two-filter extended: 29 id bits plus rtr, ide, srr compared
// - two-filter standard: 11 id bits plus rtr, ide compared
// - two-filter: regs 0-3 give hit 0, regs 4-7 give hit 1
module crf_rx_top #(
	parameter int DEPTH = crf_pkg::CRF_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic frame_error,
	input wire logic [31:0] frame_id_image,
	input wire logic [3:0] frame_dlc,
	input wire logic [63:0] frame_data,
	input wire logic transmitting,
	input wire logic arb_lost,
	input wire logic loopback,
	input wire logic overrun_irq_en,
	input wire crf_pkg::crf_mode_t filter_mode,
	input wire logic [63:0] acceptance_code_regs,
	input wire logic [63:0] acceptance_mask_regs,
	input wire logic rx_full_clear,
	output logic ack_enable,
	output logic rx_full_flag,
	output logic [2:0] filter_hit_index,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data,
	output logic [31:0] rx_id_image,
	output logic overrun_pulse,
	output logic [3:0] frames_stored
);
	initial begin
		if (DEPTH != crf_pkg::CRF_FIFO_DEPTH)
			$error("crf_rx_top supports a fifo depth of eight frames");
	end

	// ========================================
	// background buffer and own-frame tracking
	crf_pkg::crf_frame_t background_rx_buffer_reg;
	logic own_frame_reg;
	logic bg_valid_reg;
	logic own_frame_next;

	// own frame only while we still hold the bus; losing arbitration makes us a receiver
	assign own_frame_next = transmitting && !arb_lost && !loopback;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			own_frame_reg <= 1'b0;
		end else if (frame_start) begin
			own_frame_reg <= own_frame_next;
		end else if (arb_lost) begin
			own_frame_reg <= 1'b0;
		end
	end

	// no ack for own frames, except in loopback
	assign ack_enable = !own_frame_reg;

	// ========================================
	// acceptance filter
	logic [7:0] hits;
	logic [31:0] code_bank [8];
	logic [31:0] mask_bank [8];
	logic [31:0] lane_sel [8];
	logic [1:0] lanes [8];
	logic [31:0] img;
	logic is_ext;

	assign img = frame_id_image;
	assign is_ext = frame_id_image[crf_pkg::CRF_EXT_IDE_BIT];

	// per filter, pick the code/mask slice and the compared lanes by mode
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			code_bank[i] = 32'h0000_0000;
			mask_bank[i] = 32'hffff_ffff;
			lane_sel[i] = 32'h0000_0000;
			lanes[i] = 2'b00;
		end
		case (filter_mode)
			crf_pkg::CRF_MODE_TWO32: begin
				for (int i = 0; i < 2; i++) begin
					code_bank[i] = acceptance_code_regs[i*32 +: 32];
					mask_bank[i] = acceptance_mask_regs[i*32 +: 32];
					lanes[i] = 2'b11;
					// extended: all 32 image bits (29 id, srr, ide, rtr)
					// standard: 11 id bits, rtr, ide in the top 13 bits
					lane_sel[i] = is_ext ? 32'hffff_ffff : 32'hffe0_0000 | 32'h0018_0000;
				end
			end
			crf_pkg::CRF_MODE_FOUR16: begin
				for (int i = 0; i < 4; i++) begin
					code_bank[i] = {2{acceptance_code_regs[i*16 +: 16]}};
					mask_bank[i] = {2{acceptance_mask_regs[i*16 +: 16]}};
					lanes[i] = 2'b10;
					lane_sel[i] = 32'hffff_0000;
				end
			end
			crf_pkg::CRF_MODE_EIGHT8: begin
				for (int i = 0; i < 8; i++) begin
					code_bank[i] = {4{acceptance_code_regs[i*8 +: 8]}};
					mask_bank[i] = {4{acceptance_mask_regs[i*8 +: 8]}};
					lanes[i] = 2'b01;
					lane_sel[i] = 32'hff00_0000;
				end
			end
			default: begin
				// closed: nothing passes
			end
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_filt
			crf_filter u_filt (
				.id_image(img),
				.code_bank(code_bank[g]),
				.mask_bank(mask_bank[g]),
				.lanes(lanes[g]),
				.lane_sel(lane_sel[g]),
				.hit(hits[g])
			);
		end
	endgenerate

	logic any_hit;
	logic [2:0] hit_index;

	assign any_hit = |hits;

	// lowest section wins on multiple hits
	always_comb begin
		hit_index = crf_pkg::CRF_HIT_RESET;
		for (int i = 7; i >= 0; i--) begin
			if (hits[i])
				hit_index = 3'(i);
		end
	end

	// ========================================
	// background buffer capture
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			background_rx_buffer_reg <= '0;
			bg_valid_reg <= 1'b0;
		end else begin
			bg_valid_reg <= 1'b0;
			if (frame_end) begin
				// always overwritten, good or bad, own or foreign
				background_rx_buffer_reg.id_image <= frame_id_image;
				background_rx_buffer_reg.dlc <= frame_dlc;
				background_rx_buffer_reg.data <= frame_data;
				background_rx_buffer_reg.hit <= hit_index;
				// only an error-free accepted foreign frame moves on
				bg_valid_reg <= !frame_error && any_hit && !own_frame_reg;
			end
		end
	end

	// ========================================
	// receive fifo
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic push;
	logic pop;
	crf_pkg::crf_frame_t fifo_out;

	assign push = bg_valid_reg && fifo_in_ready;
	assign pop = rx_full_clear && fifo_out_valid;

	crf_fifo #(
		.WIDTH(crf_pkg::CRF_FRAME_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(bg_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(background_rx_buffer_reg),
		.out_valid(fifo_out_valid),
		.out_ready(rx_full_clear),
		.out_data(fifo_out)
	);

	// ========================================
	// overrun and occupancy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overrun_pulse <= 1'b0;
		end else begin
			// frame dropped here; transmit path is never touched
			overrun_pulse <= bg_valid_reg && !fifo_in_ready && overrun_irq_en;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frames_stored <= 4'h0;
		end else if (push && !pop) begin
			frames_stored <= frames_stored + 4'h1;
		end else if (pop && !push) begin
			frames_stored <= frames_stored - 4'h1;
		end
	end

	// ========================================
	// software view: oldest frame
	assign rx_full_flag = fifo_out_valid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			filter_hit_index <= crf_pkg::CRF_HIT_RESET;
			rx_dlc <= 4'h0;
			rx_data <= 64'h0;
			rx_id_image <= 32'h0;
		end else begin
			filter_hit_index <= fifo_out.hit;
			rx_dlc <= fifo_out.dlc;
			rx_data <= fifo_out.data;
			rx_id_image <= fifo_out.id_image;
		end
	end
endmodule

// ---- tb/crf_node_model.sv ----
`timescale 1ns/1ps
module crf_node_model (
	input wire logic clk,
	output logic frame_start,
	output logic frame_end,
	output logic frame_error,
	output logic transmitting,
	output logic arb_lost,
	output logic [31:0] frame_id_image,
	output logic [3:0] frame_dlc,
	output logic [63:0] frame_data
);
	// =====
	// bus traffic
	initial begin
		{frame_start, frame_end, frame_error, transmitting, arb_lost} = 5'h0;
		{frame_id_image, frame_dlc, frame_data} = '0;
	end
	// frame length varies so the block sees quick and slow frames
	task automatic send(input logic [31:0] id, input logic [3:0] dlc, input logic [63:0] d,
		input logic err, input logic own, input logic lose, input int len);
		@(posedge clk);
		#1;
		frame_start = 1'b1;
		transmitting = own;
		@(posedge clk);
		#1;
		frame_start = 1'b0;
		arb_lost = lose;
		repeat (len) @(posedge clk);
		#1;
		arb_lost = 1'b0;
		{frame_id_image, frame_dlc, frame_data, frame_error} = {id, dlc, d, err};
		frame_end = 1'b1;
		@(posedge clk);
		#1;
		frame_end = 1'b0;
		{frame_error, transmitting} = 2'h0;
		{frame_id_image, frame_dlc, frame_data} = ~{id, dlc, d};
	endtask
endmodule

// ---- tb/crf_rx_top_properties.sv ----
`timescale 1ns/1ps
module crf_rx_chk #(
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic frame_error,
	input wire logic transmitting,
	input wire logic arb_lost,
	input wire logic loopback,
	input wire logic overrun_irq_en,
	input wire crf_pkg::crf_mode_t filter_mode,
	input wire logic [63:0] acceptance_mask_regs,
	input wire logic rx_full_clear,
	input wire logic ack_enable,
	input wire logic rx_full_flag,
	input wire logic [2:0] filter_hit_index,
	input wire logic overrun_pulse,
	input wire logic [3:0] frames_stored
);
	// =====
	// frame properties
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_fresh;
		frame_end && !$past(frame_end);
	endsequence
	sequence s_shown;
		rx_full_flag ##1 (filter_hit_index == 3'h0);
	endsequence
	AST_DROP_ERR: assert property (s_fresh ##0 frame_error
		|-> ##2 frames_stored <= $past(frames_stored, 2)) else $error("error frame stored");
	AST_DROP_CLOSED: assert property (s_fresh ##0 filter_mode == crf_pkg::CRF_MODE_CLOSED
		|-> ##2 frames_stored <= $past(frames_stored, 2)) else $error("closed mode stored");
	AST_OWN_NOACK: assert property (frame_start && transmitting && !loopback && !arb_lost
		|=> !ack_enable) else $error("own frame acked");
	AST_LOOP_ACK: assert property (frame_start && loopback |=> ack_enable)
		else $error("loopback frame not acked");
	AST_OVR_SRC: assert property (overrun_pulse
		|-> $past(frame_end, 2) && $past(overrun_irq_en, 2)) else $error("stray overrun");
	AST_OVR_ONE: assert property (overrun_pulse |=> !overrun_pulse)
		else $error("overrun too long");
	AST_OVR_ROOM: assert property (s_fresh ##0 frames_stored < DEPTH - 1
		|-> ##2 !overrun_pulse) else $error("overrun with room");
	AST_FLAG_HOLD: assert property (rx_full_flag && !rx_full_clear |=> rx_full_flag)
		else $error("flag lost");
	AST_EMPTY: assert property (rx_full_clear && frames_stored == 4'h1 && !$past(frame_end)
		|=> !rx_full_flag) else $error("flag after last pop");
	AST_ACCEPT: assert property (s_fresh ##0 (!frame_error && ack_enable &&
		filter_mode == crf_pkg::CRF_MODE_TWO32 && (&acceptance_mask_regs[31:0]) &&
		frames_stored == 4'h0) |-> ##2 s_shown) else $error("accept not shown");
endmodule

// ---- tb/tb_crf_rx_top.sv ----
`timescale 1ns/1ps
module tb_crf_rx_top;
	logic clk, nrst, frame_start, frame_end, frame_error, transmitting, arb_lost, loopback;
	logic overrun_irq_en, rx_full_clear, ack_enable, rx_full_flag, overrun_pulse, drain;
	logic [31:0] frame_id_image, rx_id_image;
	logic [3:0] frame_dlc, rx_dlc, frames_stored;
	logic [63:0] frame_data, rx_data, acceptance_code_regs, acceptance_mask_regs;
	logic [2:0] filter_hit_index;
	crf_pkg::crf_mode_t filter_mode;
	crf_pkg::crf_frame_t exp_q[$];
	int err_total, tests_run, ovr_seen;
	crf_rx_top #(.DEPTH(8)) DUT (.clk, .nrst, .frame_start, .frame_end, .frame_error,
		.frame_id_image, .frame_dlc, .frame_data, .transmitting, .arb_lost, .loopback,
		.overrun_irq_en, .filter_mode, .acceptance_code_regs, .acceptance_mask_regs,
		.rx_full_clear, .ack_enable, .rx_full_flag, .filter_hit_index, .rx_dlc, .rx_data,
		.rx_id_image, .overrun_pulse, .frames_stored);
	crf_node_model node (.clk, .frame_start, .frame_end, .frame_error, .transmitting,
		.arb_lost, .frame_id_image, .frame_dlc, .frame_data);
	// =====
	// checks
	task automatic chk(input logic [102:0] seen, input logic [102:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic frm(input logic [31:0] id, input logic [2:0] hit, input logic keep,
		input logic err, input logic own, input logic lose);
		logic [3:0] dlc;
		logic [63:0] d;
		dlc = 4'($urandom_range(0, 8));
		d = {$urandom, $urandom};
		if (keep) begin
			exp_q.push_back('{id, dlc, d, hit});
		end
		node.send(id, dlc, d, err, own, lose, $urandom_range(1, 4));
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic wait_empty();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || rx_full_flag !== 1'b0) && n < 500) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 500) begin
			err_total++;
			test_done();
		end
	endtask
	// pops slowly on purpose, one frame per four cycles
	always begin
		@(posedge clk);
		#1;
		if (drain && rx_full_flag === 1'b1) begin
			@(posedge clk);
			#1;
			if (exp_q.size() == 0) begin
				chk(1'b1, 1'b0);
			end else begin
				chk({rx_id_image, rx_dlc, rx_data, filter_hit_index}, exp_q.pop_front());
			end
			rx_full_clear = 1'b1;
			@(posedge clk);
			#1;
			rx_full_clear = 1'b0;
			@(posedge clk);
		end
	end
	always @(posedge clk) begin
		if (overrun_pulse === 1'b1) begin
			ovr_seen++;
		end
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// =====
	// sequence
	initial begin
		logic [31:0] ids [7] = '{32'ha5a5a5a5, 32'ha5a5a5a4, 32'ha5ada5a5, 32'ha5a6a5a5,
			32'hb5a5a5a5, 32'ha5a50000, 32'ha5000000};
		// second id is a standard frame: bit 0 lies outside the compared lanes
		logic [2:0] hits [7] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h0};
		logic [7:0] mks [7] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h0f, 8'h00, 8'h00};
		logic [1:0] mds [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
		void'($urandom(32'h1941c553));
		{nrst, loopback, rx_full_clear, err_total, tests_run, ovr_seen} = '0;
		{overrun_irq_en, drain} = 2'h3;
		filter_mode = crf_pkg::CRF_MODE_TWO32;
		acceptance_code_regs = {32'h0, 32'ha5a5a5a5};
		acceptance_mask_regs = {32'hffffffff, 32'h0};
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk({ack_enable, rx_full_flag, frames_stored}, 6'h20);
		// ide, mask, bank and mode cases
		for (int i = 0; i < 7; i++) begin
			filter_mode = crf_pkg::crf_mode_t'(mds[i]);
			acceptance_mask_regs[31:0] = {4{mks[i]}};
			frm(ids[i], hits[i], 1'b1, 1'b0, 1'b0, 1'b0);
		end
		filter_mode = crf_pkg::CRF_MODE_TWO32;
		acceptance_mask_regs[31:0] = 32'h0;
		frm(32'ha5a5a5a5, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		filter_mode = crf_pkg::CRF_MODE_CLOSED;
		frm(32'ha5a5a5a5, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		filter_mode = crf_pkg::CRF_MODE_TWO32;
		frm(32'ha5a5a5a5, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
		loopback = 1'b1;
		frm(32'ha5a5a5a5, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
		loopback = 1'b0;
		frm(32'ha5a5a5a5, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1);
		// bit 31 cleared: always differs from bank 0 in a compared lane
		repeat (4) frm($urandom & 32'h7fffffff, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
		wait_empty();
		// fill, overflow, then drain
		drain = 1'b0;
		acceptance_mask_regs = '1;
		repeat (8) frm($urandom, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		chk(frames_stored, 4'h8);
		frm($urandom, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		overrun_irq_en = 1'b0;
		frm($urandom, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(ovr_seen, 1);
		overrun_irq_en = 1'b1;
		drain = 1'b1;
		wait_empty();
		frm($urandom, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		wait_empty();
		test_done();
	end
endmodule
bind crf_rx_top crf_rx_chk #(.DEPTH(DEPTH)) u_chk (.clk, .nrst, .frame_start, .frame_end,
	.frame_error, .transmitting, .arb_lost, .loopback, .overrun_irq_en, .filter_mode,
	.acceptance_mask_regs, .rx_full_clear, .ack_enable, .rx_full_flag, .filter_hit_index,
	.overrun_pulse, .frames_stored);
